// *** ufa_fifo_access.sv ***
/*
 ufa_fifo_access: command/status register through which firmware claims one of
 four endpoint fifos, reads or writes its bytes, or empties it; also flags setup
 and zero-length packets reported by the serial interface engine.
 assumes an avalon-mm master on core_clk, an engine on core_clk giving per-endpoint
 ready levels, head byte and one-cycle event pulses, and an asynchronous usb bus
 reset level.
 registers sit at their index times four on the byte-addressed bus; only byte
 lane zero carries them, the upper readdata bits are zero.
 every access takes two edges: the first latches the answer and lowers
 waitrequest, the second applies any side effect.
 the settle time after a claim, a new select, a turned direction, a clear or a
 byte is counted here; firmware that polls ready early simply sees it low.
 data port accesses outside a matching claim read zero and are not forwarded.
 interrupt status bits are sticky and a status read clears the bits it showed;
 an event in the same cycle as the clear stays set.
 a usb bus reset leaves status and mask alone and clears only the command
 register; pulses already on their way to the engine are dropped.
*/
`timescale 1ns/1ns
`default_nettype none
module ufa_fifo_access (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [ufa_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   input wire logic usb_bus_reset,
   input wire logic sie_setup_pulse,
   input wire logic sie_zlp_pulse,
   input wire logic [3:0] ep_ready,
   input wire logic [7:0] fifo_rdata,
   output logic fifo_req,
   output logic fifo_tx,
   output logic [1:0] fifo_sel,
   output logic fifo_rd_pulse,
   output logic fifo_wr_pulse,
   output logic [7:0] fifo_wdata,
   output logic fifo_clear_pulse
);
   typedef struct packed {
      logic req;
      logic tx;
      logic clr;
      logic [1:0] sel;
      logic setup;
      logic ready;
      logic zlp;
      logic ack;
      logic [31:0] rdata;
      logic [ufa_pkg::IRQ_W-1:0] sts;
      logic [ufa_pkg::IRQ_W-1:0] mask;
      logic rd_p;
      logic wr_p;
      logic [7:0] wdata;
      logic clr_p;
   } ufa_state_t;

   localparam logic [ufa_pkg::ADDR_W-1:0] MISC_ADDR = {ufa_pkg::MISC_IDX, 2'b00};
   localparam logic [ufa_pkg::ADDR_W-1:0] ENDPOINT0_DATA_PORT_ADDR = {ufa_pkg::ENDPOINT0_DATA_PORT_IDX, 2'b00};
   localparam logic [ufa_pkg::ADDR_W-1:0] FIFO1_ADDR = {ufa_pkg::FIFO1_IDX, 2'b00};
   localparam logic [ufa_pkg::ADDR_W-1:0] FIFO2_ADDR = {ufa_pkg::FIFO2_IDX, 2'b00};
   localparam logic [ufa_pkg::ADDR_W-1:0] FIFO3_ADDR = {ufa_pkg::FIFO3_IDX, 2'b00};
   localparam logic [ufa_pkg::ADDR_W-1:0] STS_ADDR = {ufa_pkg::IRQ_STS_IDX, 2'b00};
   localparam logic [ufa_pkg::ADDR_W-1:0] MASK_ADDR = {ufa_pkg::IRQ_MASK_IDX, 2'b00};

   ufa_state_t q;
   ufa_state_t d;
   logic bus_rst_s;
   logic settle_done;
   logic settle_start;
   logic [7:0] misc_rd;
   logic [7:0] wbyte;
   logic hit_misc;
   logic hit_fifo;
   logic hit_sts;
   logic hit_mask;
   logic [1:0] port_ep;
   logic rd_ok;
   logic wr_ok;
   logic new_req;
   logic new_clr;
   logic [1:0] new_sel;
   logic claim_match;
   logic bus_req;
   logic bus_take;
   logic bus_done;

   // the bus reset level comes from the line monitor, not from core_clk
   ufa_sync3 u_bus_rst_sync (
      .core_clk(core_clk),
      .rst(rst),
      .async_in(usb_bus_reset),
      .sync_out(bus_rst_s)
   );

   // one shared timer: a new start simply restarts the count
   ufa_settle_timer u_settle (
      .core_clk(core_clk),
      .rst(rst),
      .start(settle_start),
      .done(settle_done)
   );

   always_comb
   begin
      misc_rd = '0;
      misc_rd[ufa_pkg::MISC_REQ] = q.req;
      misc_rd[ufa_pkg::MISC_TX] = q.tx;
      misc_rd[ufa_pkg::MISC_CLR] = q.clr;
      misc_rd[ufa_pkg::MISC_SEL_HI:ufa_pkg::MISC_SEL_LO] = q.sel;
      misc_rd[ufa_pkg::MISC_SETUP] = q.setup;
      misc_rd[ufa_pkg::MISC_READY] = q.ready;
      misc_rd[ufa_pkg::MISC_ZLP] = q.zlp;
   end

   // address decode
   always_comb
   begin
      hit_misc = 1'b0;
      hit_fifo = 1'b0;
      hit_sts = 1'b0;
      hit_mask = 1'b0;
      port_ep = 2'h0;
      if (avs_address == MISC_ADDR)
      begin
         hit_misc = 1'b1;
      end
      else if (avs_address == ENDPOINT0_DATA_PORT_ADDR)
      begin
         hit_fifo = 1'b1;
         port_ep = 2'h0;
      end
      else if (avs_address == FIFO1_ADDR)
      begin
         hit_fifo = 1'b1;
         port_ep = 2'h1;
      end
      else if (avs_address == FIFO2_ADDR)
      begin
         hit_fifo = 1'b1;
         port_ep = 2'h2;
      end
      else if (avs_address == FIFO3_ADDR)
      begin
         hit_fifo = 1'b1;
         port_ep = 2'h3;
      end
      else if (avs_address == STS_ADDR)
      begin
         hit_sts = 1'b1;
      end
      else if (avs_address == MASK_ADDR)
      begin
         hit_mask = 1'b1;
      end
   end

   // byte moves only for the claimed endpoint, in the claimed direction, while ready
   assign claim_match = hit_fifo && q.req && q.ready && (port_ep == q.sel);
   assign rd_ok = claim_match && !q.tx;
   assign wr_ok = claim_match && q.tx;

   // an access is taken at its first edge and completes at its second
   assign bus_req = avs_read || avs_write;
   assign bus_take = bus_req && !q.ack;
   assign bus_done = bus_req && q.ack;

   // only the low byte lane carries the 8-bit registers
   assign wbyte = avs_byteenable[0] ? avs_writedata[7:0] : misc_rd;
   assign new_req = wbyte[ufa_pkg::MISC_REQ];
   assign new_clr = wbyte[ufa_pkg::MISC_CLR];
   assign new_sel = wbyte[ufa_pkg::MISC_SEL_HI:ufa_pkg::MISC_SEL_LO];

   always_comb
   begin
      d = q;
      d.rd_p = 1'b0;
      d.wr_p = 1'b0;
      d.clr_p = 1'b0;
      settle_start = 1'b0;

      // first edge of an access: latch the answer, drop waitrequest next cycle
      if (bus_take)
      begin
         d.ack = 1'b1;
         // unmapped addresses and refused port reads answer zero
         d.rdata = '0;
         if (avs_read)
         begin
            if (hit_misc)
            begin
               d.rdata = {24'h000000, misc_rd};
            end
            else if (rd_ok)
            begin
               d.rdata = {24'h000000, fifo_rdata};
            end
            else if (hit_sts)
            begin
               d.rdata = {29'h00000000, q.sts};
            end
            else if (hit_mask)
            begin
               d.rdata = {29'h00000000, q.mask};
            end
         end
      end
      // second edge: waitrequest is low, side effects take place here
      else if (bus_done)
      begin
         d.ack = 1'b0;
         if (avs_write && hit_misc && avs_byteenable[0])
         begin
            d.req = new_req;
            d.tx = wbyte[ufa_pkg::MISC_TX];
            d.clr = new_clr;
            d.sel = new_sel;
            // flags only clear on a written zero; a written one leaves them
            if (!wbyte[ufa_pkg::MISC_SETUP])
            begin
               d.setup = 1'b0;
            end
            if (!wbyte[ufa_pkg::MISC_ZLP])
            begin
               d.zlp = 1'b0;
            end
            // a fresh claim, new endpoint or turned direction restarts the settle time
            if ((new_req && !q.req) || (new_sel != q.sel) || (wbyte[ufa_pkg::MISC_TX] != q.tx))
            begin
               settle_start = 1'b1;
            end
            // clear does not wait for ready
            if (new_req && new_clr && !(q.req && q.clr))
            begin
               d.clr_p = 1'b1;
               settle_start = 1'b1;
            end
         end
         else if (avs_write && wr_ok && avs_byteenable[0])
         begin
            d.wr_p = 1'b1;
            d.wdata = avs_writedata[7:0];
            settle_start = 1'b1;
         end
         else if (avs_write && hit_mask && avs_byteenable[0])
         begin
            d.mask = avs_writedata[ufa_pkg::IRQ_W-1:0];
         end
         else if (avs_read && rd_ok)
         begin
            d.rd_p = 1'b1;
            settle_start = 1'b1;
         end
         else if (avs_read && hit_sts)
         begin
            // only bits that were reported are cleared
            d.sts = q.sts & ~q.rdata[ufa_pkg::IRQ_W-1:0];
         end
      end

      // ready withheld during the settle time after a claim or a byte
      // it follows the new claim, so dropping the request hides it at once
      d.ready = d.req && ep_ready[d.sel] && settle_done && !settle_start;

      // engine events come after the clears so that a set wins
      if (sie_setup_pulse)
      begin
         d.setup = 1'b1;
         d.sts[ufa_pkg::IRQ_SETUP] = 1'b1;
      end
      if (sie_zlp_pulse)
      begin
         d.zlp = 1'b1;
         d.sts[ufa_pkg::IRQ_ZLP] = 1'b1;
      end
      if (d.ready && !q.ready)
      begin
         d.sts[ufa_pkg::IRQ_READY] = 1'b1;
      end

      // bus reset returns the whole command/status register to zero
      // status and mask are left alone, so a pending interrupt survives it
      if (bus_rst_s)
      begin
         d.req = ufa_pkg::MISC_RST[ufa_pkg::MISC_REQ];
         d.tx = ufa_pkg::MISC_RST[ufa_pkg::MISC_TX];
         d.clr = ufa_pkg::MISC_RST[ufa_pkg::MISC_CLR];
         d.sel = ufa_pkg::MISC_RST[ufa_pkg::MISC_SEL_HI:ufa_pkg::MISC_SEL_LO];
         d.setup = ufa_pkg::MISC_RST[ufa_pkg::MISC_SETUP];
         d.ready = ufa_pkg::MISC_RST[ufa_pkg::MISC_READY];
         d.zlp = ufa_pkg::MISC_RST[ufa_pkg::MISC_ZLP];
         d.rd_p = 1'b0;
         d.wr_p = 1'b0;
         d.clr_p = 1'b0;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         q <= '0;
         q.mask <= ufa_pkg::IRQ_MASK_RST;
      end
      else
      begin
         q <= d;
      end
   end

   // handshake is combinational, data comes from flops
   assign avs_waitrequest = bus_take;
   assign avs_readdata = q.rdata;
   // level output; only a status read or a mask write lowers it
   assign irq = |(q.sts & q.mask);
   assign fifo_req = q.req;
   assign fifo_tx = q.tx;
   assign fifo_sel = q.sel;
   assign fifo_rd_pulse = q.rd_p;
   assign fifo_wr_pulse = q.wr_p;
   assign fifo_wdata = q.wdata;
   assign fifo_clear_pulse = q.clr_p;
endmodule
`default_nettype wire

// *** ufa_pkg.sv ***
/*
 ufa_pkg: register map, field positions, reset values and timing counts for the
 endpoint fifo command/status block.
 assumes a 100 MHz core clock and a 32-bit avalon-mm register bus.
*/
`default_nettype none
package ufa_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] MISC_IDX = 8'h46;
   localparam logic [7:0] ENDPOINT0_DATA_PORT_IDX = 8'h48;
   localparam logic [7:0] FIFO1_IDX = 8'h49;
   localparam logic [7:0] FIFO2_IDX = 8'h4a;
   localparam logic [7:0] FIFO3_IDX = 8'h4b;
   localparam logic [7:0] IRQ_STS_IDX = 8'h50;
   localparam logic [7:0] IRQ_MASK_IDX = 8'h51;
   localparam int ADDR_W = 10;

   // command/status field positions
   localparam int MISC_REQ = 0;
   localparam int MISC_TX = 1;
   localparam int MISC_CLR = 2;
   localparam int MISC_SEL_LO = 3;
   localparam int MISC_SEL_HI = 4;
   localparam int MISC_SETUP = 5;
   localparam int MISC_READY = 6;
   localparam int MISC_ZLP = 7;
   localparam logic [7:0] MISC_RST = 8'h00;

   // interrupt status/mask layout
   localparam int IRQ_SETUP = 0;
   localparam int IRQ_ZLP = 1;
   localparam int IRQ_READY = 2;
   localparam int IRQ_W = 3;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;

   // settle time before ready may show, and between byte accesses
   localparam int CLK_PERIOD_NS = 10;
   localparam int SETTLE_NS = 2000;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TMR_W = 8;
endpackage
`default_nettype wire

// *** ufa_props.sv ***
/*
 ufa_props: port assertions for ufa_fifo_access.
 assumes the bind below and one core_clk domain with synchronous rst.
*/
`timescale 1ns/1ns
`default_nettype none
module ufa_props (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [31:0] avs_readdata,
   input wire logic usb_bus_reset,
   input wire logic fifo_req,
   input wire logic fifo_tx,
   input wire logic [1:0] fifo_sel,
   input wire logic fifo_rd_pulse,
   input wire logic fifo_wr_pulse,
   input wire logic fifo_clear_pulse
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   logic [8:0] gap_q;
   // saturating count of cycles since the last byte access
   always_ff @(posedge core_clk)
   begin
      if (rst || fifo_rd_pulse || fifo_wr_pulse)
         gap_q <= 9'h000;
      else if (gap_q != 9'h1ff)
         gap_q <= gap_q + 9'h001;
   end
   AST_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest held past one cycle");
   AST_RD_GATE: assert property (fifo_rd_pulse |-> $past(fifo_req && !fifo_tx))
      else $error("pop without read request");
   AST_WR_GATE: assert property (fifo_wr_pulse |-> $past(fifo_req && fifo_tx))
      else $error("push without write request");
   AST_RD_BUS: assert property (fifo_rd_pulse |-> $past(avs_read && !avs_waitrequest))
      else $error("pop without bus read");
   AST_WR_BUS: assert property (fifo_wr_pulse |-> $past(avs_write && !avs_waitrequest))
      else $error("push without bus write");
   AST_CLR: assert property (fifo_clear_pulse |-> fifo_req ##1 !fifo_clear_pulse)
      else $error("clear pulse malformed");
   AST_GAP: assert property ((fifo_rd_pulse || fifo_wr_pulse) |-> gap_q >= 9'h0c7)
      else $error("byte accesses too close");
   AST_BUSRST: assert property (usb_bus_reset [*6] |-> !fifo_req && !fifo_tx && fifo_sel == 2'h0)
      else $error("bus reset did not clear command");
   AST_RDATA: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
      else $error("readdata upper bits set");
   COV_RD: cover property (fifo_rd_pulse);
   COV_WR: cover property (fifo_wr_pulse);
   COV_CLR: cover property (fifo_clear_pulse);
endmodule
bind ufa_fifo_access ufa_props ufa_props_i (.core_clk(core_clk), .rst(rst), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
   .usb_bus_reset(usb_bus_reset), .fifo_req(fifo_req), .fifo_tx(fifo_tx), .fifo_sel(fifo_sel),
   .fifo_rd_pulse(fifo_rd_pulse), .fifo_wr_pulse(fifo_wr_pulse), .fifo_clear_pulse(fifo_clear_pulse));
`default_nettype wire

// *** ufa_settle_timer.sv ***
/*
 ufa_settle_timer: counts down the settle time after a start pulse.
 assumes start is a one-cycle pulse from logic on core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module ufa_settle_timer (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic start,
   output logic done
);
   typedef struct packed {
      logic [ufa_pkg::TMR_W-1:0] cnt;
   } ufa_tmr_t;

   ufa_tmr_t q;
   ufa_tmr_t d;

   always_comb
   begin
      d = q;
      if (start)
      begin
         d.cnt = ufa_pkg::TMR_W'(ufa_pkg::SETTLE_CYC);
      end
      else if (q.cnt != '0)
      begin
         d.cnt = q.cnt - 1'b1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign done = (q.cnt == '0);
endmodule
`default_nettype wire

// *** ufa_sie_model.sv ***
/*
 ufa_sie_model: behavioural engine with four small endpoint fifos.
 assumes setup_cmd and zlp_cmd come from the bench, one cycle each.
*/
`timescale 1ns/1ns
`default_nettype none
module ufa_sie_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic fifo_tx,
   input wire logic [1:0] fifo_sel,
   input wire logic fifo_rd_pulse,
   input wire logic fifo_wr_pulse,
   input wire logic [7:0] fifo_wdata,
   input wire logic fifo_clear_pulse,
   input wire logic setup_cmd,
   input wire logic zlp_cmd,
   output logic [3:0] ep_ready,
   output logic [7:0] fifo_rdata,
   output logic sie_setup_pulse,
   output logic sie_zlp_pulse
);
   logic [7:0] q [4][$];
   logic [7:0] cyc = 8'h00;
   always @(posedge core_clk)
   begin
      cyc <= cyc + 8'h01;
      sie_setup_pulse <= setup_cmd && !rst;
      sie_zlp_pulse <= zlp_cmd && !rst;
      // empty fifo shows a changing pattern, never a stale byte
      fifo_rdata <= (q[fifo_sel].size() > 0) ? q[fifo_sel][0] : cyc;
      for (int i = 0; i < 4; i++)
         ep_ready[i] <= fifo_tx ? (q[i].size() < 4) : (q[i].size() > 0);
      if (rst)
         for (int i = 0; i < 4; i++)
            q[i].delete();
      else if (fifo_clear_pulse)
         q[fifo_sel].delete();
      else if (fifo_wr_pulse)
         q[fifo_sel].push_back(fifo_wdata);
      else if (fifo_rd_pulse && q[fifo_sel].size() > 0)
         void'(q[fifo_sel].pop_front());
   end
endmodule
`default_nettype wire

// *** ufa_sync3.sv ***
/*
 ufa_sync3: three-stage synchroniser for one level from outside the clock domain.
 assumes the input is a slow level; the output follows once stages two and three agree.
*/
`timescale 1ns/1ns
`default_nettype none
module ufa_sync3 (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic async_in,
   output logic sync_out
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic out;
   } ufa_sync_t;

   ufa_sync_t q;
   ufa_sync_t d;

   always_comb
   begin
      d = q;
      d.s1 = async_in;
      d.s2 = q.s1;
      d.s3 = q.s2;
      // s1 feeds only s2; the agreement check looks at later stages
      if (q.s2 == q.s3)
      begin
         d.out = q.s3;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign sync_out = q.out;
endmodule
`default_nettype wire

// *** usb_endpoint_fifo_access_control_tb.sv ***
/*
 usb_endpoint_fifo_access_control_tb: self-checking bench for ufa_fifo_access.
 assumes the engine model ufa_sie_model and the bound checker ufa_props.
*/
`timescale 1ns/1ns
`default_nettype none
module usb_endpoint_fifo_access_control_tb;
   typedef struct packed {logic [7:0] misc; logic [1:0] sel; logic tx;} ufa_row_t;
   localparam logic [9:0] A_MISC = {ufa_pkg::MISC_IDX, 2'b00};
   localparam logic [9:0] A_FIFO = {ufa_pkg::ENDPOINT0_DATA_PORT_IDX, 2'b00};
   localparam logic [9:0] A_STS = {ufa_pkg::IRQ_STS_IDX, 2'b00};
   localparam logic [9:0] A_MASK = {ufa_pkg::IRQ_MASK_IDX, 2'b00};
   logic core_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, usb_bus_reset = 1'b0;
   logic [9:0] avs_address = 10'h000;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, v;
   logic avs_waitrequest, irq, sie_setup_pulse, sie_zlp_pulse, fifo_req, fifo_tx;
   logic fifo_rd_pulse, fifo_wr_pulse, fifo_clear_pulse, setup_cmd = 1'b0, zlp_cmd = 1'b0;
   logic [3:0] ep_ready;
   logic [7:0] fifo_rdata, fifo_wdata;
   logic [1:0] fifo_sel;
   int n_fail = 0, check_count = 0;
   ufa_row_t rows [4] = '{'{8'h01, 2'h0, 1'b0}, '{8'h0b, 2'h1, 1'b1}, '{8'h11, 2'h2, 1'b0}, '{8'h1b, 2'h3, 1'b1}};
   always #5 core_clk = ~core_clk;
   ufa_fifo_access ufa_fifo_access_i (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .usb_bus_reset(usb_bus_reset),
      .sie_setup_pulse(sie_setup_pulse), .sie_zlp_pulse(sie_zlp_pulse), .ep_ready(ep_ready),
      .fifo_rdata(fifo_rdata), .fifo_req(fifo_req), .fifo_tx(fifo_tx), .fifo_sel(fifo_sel),
      .fifo_rd_pulse(fifo_rd_pulse), .fifo_wr_pulse(fifo_wr_pulse), .fifo_wdata(fifo_wdata),
      .fifo_clear_pulse(fifo_clear_pulse));
   ufa_sie_model ufa_sie_model_i (.core_clk(core_clk), .rst(rst), .fifo_tx(fifo_tx), .fifo_sel(fifo_sel),
      .fifo_rd_pulse(fifo_rd_pulse), .fifo_wr_pulse(fifo_wr_pulse), .fifo_wdata(fifo_wdata),
      .fifo_clear_pulse(fifo_clear_pulse), .setup_cmd(setup_cmd), .zlp_cmd(zlp_cmd), .ep_ready(ep_ready),
      .fifo_rdata(fifo_rdata), .sie_setup_pulse(sie_setup_pulse), .sie_zlp_pulse(sie_zlp_pulse));
   task test_done();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // values read right after the edge are the pre-edge ones, as the slave presented them
   task bus(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge core_clk);
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50)
      begin
         n_fail++;
         test_done();
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task misc(input logic [7:0] m);
      bus(1'b1, A_MISC, {24'h0, m}, v);
   endtask
   task wait_ready();
      int n;
      repeat (ufa_pkg::SETTLE_CYC) @(posedge core_clk);
      n = 0;
      do
      begin
         bus(1'b0, A_MISC, 32'h0, v);
         n++;
      end
      while (v[ufa_pkg::MISC_READY] !== 1'b1 && n < 40);
      if (n >= 40)
      begin
         n_fail++;
         test_done();
      end
   endtask
   task fifo_wr(input logic [1:0] s, input logic [7:0] d);
      misc({3'h0, s, 3'b010});
      misc({3'h0, s, 3'b011});
      wait_ready();
      bus(1'b1, A_FIFO + {6'h0, s, 2'b00}, {24'h0, d}, v);
      // push pulse leaves the block at the edge the write ends on, the model stores it at the next edge
      repeat (2) @(negedge core_clk);
   endtask
   task pulse(input logic z);
      @(posedge core_clk);
      setup_cmd <= !z;
      zlp_cmd <= z;
      @(posedge core_clk);
      setup_cmd <= 1'b0;
      zlp_cmd <= 1'b0;
      repeat (2) @(negedge core_clk);
   endtask
   initial
   begin
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      bus(1'b0, A_MISC, 32'h0, v);
      chk(v, {24'h0, ufa_pkg::MISC_RST});
      bus(1'b0, A_MASK, 32'h0, v);
      chk(v, 32'h0);
      bus(1'b1, 10'h3f0, 32'h5a, v);
      bus(1'b0, 10'h3f0, 32'h0, v);
      chk(v, 32'h0);
      misc(8'h40);
      bus(1'b0, A_MISC, 32'h0, v);
      chk(v, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         misc(rows[i].misc);
         @(negedge core_clk);
         chk(fifo_sel, rows[i].sel);
         chk(fifo_tx, rows[i].tx);
         chk(fifo_req, 1'b1);
         bus(1'b0, A_MISC, 32'h0, v);
         chk(v & 32'h1f, rows[i].misc);
         misc(8'h00);
      end
      fifo_wr(2'h1, 8'ha5);
      chk(ufa_sie_model_i.q[1].size(), 1);
      bus(1'b0, A_MISC, 32'h0, v);
      chk(v[ufa_pkg::MISC_READY], 1'b0);
      // deliberately too soon: must be ignored
      bus(1'b1, A_FIFO + 10'h004, 32'h3c, v);
      repeat (2) @(negedge core_clk);
      chk(ufa_sie_model_i.q[1].size(), 1);
      misc(8'h09);
      misc(8'h08);
      misc(8'h09);
      wait_ready();
      bus(1'b0, A_FIFO + 10'h004, 32'h0, v);
      chk(v, 32'ha5);
      bus(1'b0, A_FIFO, 32'h0, v);
      chk(v, 32'h0);
      chk(ufa_sie_model_i.q[1].size(), 0);
      misc(8'h0b);
      misc(8'h0a);
      fifo_wr(2'h1, 8'hb7);
      chk(ufa_sie_model_i.q[1].size(), 1);
      misc(8'h0f);
      repeat (2) @(negedge core_clk);
      chk(ufa_sie_model_i.q[1].size(), 0);
      misc(8'h09);
      bus(1'b1, A_MASK, 32'h3, v);
      pulse(1'b0);
      chk(irq, 1'b1);
      bus(1'b0, A_MISC, 32'h0, v);
      chk(v[ufa_pkg::MISC_SETUP], 1'b1);
      bus(1'b0, A_STS, 32'h0, v);
      chk(v[ufa_pkg::IRQ_SETUP], 1'b1);
      chk(v[ufa_pkg::IRQ_READY], 1'b1);
      @(negedge core_clk);
      chk(irq, 1'b0);
      bus(1'b0, A_MISC, 32'h0, v);
      chk(v[ufa_pkg::MISC_SETUP], 1'b1);
      misc(8'h09);
      bus(1'b0, A_MISC, 32'h0, v);
      chk(v[ufa_pkg::MISC_SETUP], 1'b0);
      pulse(1'b1);
      chk(irq, 1'b1);
      bus(1'b0, A_MISC, 32'h0, v);
      chk(v[ufa_pkg::MISC_ZLP], 1'b1);
      bus(1'b1, A_MASK, 32'h0, v);
      bus(1'b0, A_STS, 32'h0, v);
      chk(v[ufa_pkg::IRQ_ZLP], 1'b1);
      pulse(1'b1);
      chk(irq, 1'b0);
      misc(8'h1b);
      usb_bus_reset <= 1'b1;
      repeat (8) @(negedge core_clk);
      chk(fifo_req, 1'b0);
      bus(1'b0, A_MISC, 32'h0, v);
      chk(v, 32'h0);
      usb_bus_reset <= 1'b0;
      repeat (8) @(posedge core_clk);
      test_done();
   end
endmodule
`default_nettype wire
